/* pms_host.sv */
// Host side of the serial port: frames, link clock, MISO wire level.
// Assumes the device drives MISO only with spi_miso_oe high.
module pms_host (
   output logic      spi_sclk,
   output logic      port_select_n,
   output logic      spi_mosi,
   input  wire logic spi_miso_o,
   input  wire logic spi_miso_oe,
   input  wire logic miso_pd_en
);
   timeunit 1ns;
   timeprecision 100ps;
   logic miso_last;
   logic miso_line;
   // A released line without pull-down shows the inverse of its last value.
   assign miso_line = spi_miso_oe ? spi_miso_o : (miso_pd_en ? 1'b0 : !miso_last);
   initial begin
      spi_sclk = 1'b0;
      port_select_n = 1'b1;
      spi_mosi = 1'b0;
      miso_last = 1'b0;
   end
   // The link clock runs only inside a frame, MSB first, 80 ns period.
   task automatic frame(input logic [23:0] tx, input int nbits, output logic [23:0] rx);
      rx = 24'h0;
      #7 port_select_n = 1'b0;
      for (int i = 0; i < nbits; i++) begin
         #20 spi_mosi = tx[23-i];
         #20 spi_sclk = 1'b1;
         #40 rx[23-i] = miso_line;
         spi_sclk = 1'b0;
         if (spi_miso_oe) miso_last = spi_miso_o;
      end
      #40 port_select_n = 1'b1;
      spi_mosi = !spi_mosi;
      #80;
   endtask
endmodule

/* pms_pkg.sv */
// Types shared by the power mode block.
// Assumes pms_regs.svh supplies the numeric constants.
package pms_pkg;
   typedef enum logic [1:0] {
      PMS_OP_WRITE = 2'b00,
      PMS_OP_READ  = 2'b01,
      PMS_OP_CMD   = 2'b10,
      PMS_OP_RSVD  = 2'b11
   } pms_op_t;
   typedef enum logic [1:0] {PMS_PWR_DOWN, PMS_PWR_STANDBY, PMS_PWR_NORMAL} pms_pwr_t;
   typedef enum logic [1:0] {PMS_RF_OFF, PMS_RF_UP, PMS_FIELD_ENABLE_BIT, PMS_RF_DOWN} pms_rf_t;
   typedef enum logic {PMS_SEQ_IDLE, PMS_SEQ_STEP} pms_seq_t;
   typedef struct packed {
      logic regs_on;
      logic low_power;
      logic pll_on;
      logic tx_on;
      logic rx_on;
   } pms_pwr_ctl_t;
endpackage

/* pms_regs.svh */
// Register offsets, field positions, reset values and timing counts of the power mode block.
// Assumes a 40 MHz system clock and a host serial link clocked by the host.
//
// Overview of operation
// R01 - Auto level command steps regulators below supply.
// R02 - Manual level command restores register-selected voltages.
// R03 - Host locks PLL in band before auto.
// R04 - Auto start sets top level, field on.
// R05 - One 100 mV step per 300 us, floor.
// R06 - Stop on gap or floor; field off, irq.
// R07 - Enable pin low forces full power-down.
// R08 - Standby bit gives low power, blocks off.
// R09 - Registers keep values across standby transitions.
// R10 - Host waits 12 ms after leaving standby.
// R11 - Enable high gives normal mode, field off.
// R12 - Host waits 12 ms after enable rises.
// R13 - Oscillator-stable status bit shown for polling.
// R14 - Host waits 500 ms before field use.
// R15 - Field enable bit starts ramp at once.
// R16 - Ramp-up end sets ready, analog irq.
// R17 - Ramp-down end clears ready, analog irq.
// R18 - Normal to active field takes 12.5 us.
// R19 - Port active only while select is low.
// R20 - Data sampled on falling edge, MSB first.
// R21 - Two top bits select operation type.
// R22 - Address increments for each following byte.
// R23 - Output released unless reading; optional pull-down.
// R24 - Partial byte at frame end not written.
// R25 - Writes to absent or read-only registers ignored.
// R26 - Reads of absent registers return zero.
// R27 - Command acts on its last falling edge.
// R28 - Reserved operation code frame is ignored.
// R29 - Power-down aborts the auto level sequencer.
`ifndef PMS_REGS_SVH
`define PMS_REGS_SVH
`define PMS_ADDR_STATE  6'h00
`define PMS_ADDR_MISC   6'h0D
`define PMS_ADDR_MOD3   6'h15
`define PMS_ADDR_STATUS 6'h2A
`define PMS_ADDR_IRQ    6'h38
`define PMS_RST_STATE   8'h00
`define PMS_RST_MISC    8'h00
`define PMS_RST_MOD3    8'h00
`define PMS_BIT_FIELD   7
`define PMS_BIT_STBY    6
`define PMS_BIT_PD_A    0
`define PMS_BIT_PD_B    1
`define PMS_BIT_LIN     2
`define PMS_BIT_TRF     0
`define PMS_BIT_OSC     7
`define PMS_BIT_READY   6
`define PMS_BIT_IRQ_ANA 0
`define PMS_BIT_IRQ_CMD 1
`define PMS_CMD_AUTO    6'h22
`define PMS_CMD_MAN     6'h23
`define PMS_LVL_TOP     3'h7
`define PMS_LVL_FLOOR   3'h0
`define PMS_CLK_KHZ     40000
`define PMS_STEP_US     300
`define PMS_STEP_CYC    (`PMS_STEP_US * `PMS_CLK_KHZ / 1000)
`define PMS_RAMP_NS     12500
`define PMS_RAMP_CYC    (`PMS_RAMP_NS * `PMS_CLK_KHZ / 1000000)
`endif

/* pms_top.sv */
// Power mode control, field ramp, auto supply level sequencer and host serial port.
// Assumes the serial clock is a separate domain that runs only inside frames.
`include "pms_regs.svh"
module pms_top #(
   parameter int STEP_CYC = `PMS_STEP_CYC
) (
   input  wire logic                  clk_sys,
   input  wire logic                  rst,
   input  wire logic                  ce,
   input  wire logic                  en,
   input  wire logic                  osc_stable,
   input  wire logic                  supply_gap_ok,
   input  wire logic [2:0]            reg_sel_level,
   input  wire logic                  spi_sclk,
   input  wire logic                  port_select_n,
   input  wire logic                  spi_mosi,
   output logic                       spi_miso_o,
   output logic                       spi_miso_oe,
   output logic                       miso_pd_en,
   output logic                       irq,
   output logic                       host_clock_output,
   output logic [2:0]                 regulator_level,
   output logic                       field_on,
   output logic                       field_ramping,
   output logic                       ramp_linear,
   output logic [1:0]                 ramp_time,
   output pms_pkg::pms_pwr_ctl_t      pwr_ctl
);

   // ********************************************************************
   // Serial link domain
   // ********************************************************************

   logic                 frame_rst;
   logic [2:0]           bit_cnt;
   logic [6:0]           shreg;
   logic                 first_done;
   pms_pkg::pms_op_t     op;
   logic [5:0]           addr;
   logic [7:0]           rx_byte;
   logic                 byte_end;
   logic [7:0]           state_reg;
   logic [7:0]           misc_reg;
   logic [7:0]           mod3_reg;
   logic [5:0]           cmd_id;
   logic                 cmd_tgl;
   logic                 clr_tgl;
   logic [7:0]           tx_byte;
   logic [3:0]           st_meta;
   logic [3:0]           st_link;
   logic [5:0]           rd_addr;
   logic                 rd_load;
   logic                 osc_s;
   logic                 field_ready;
   logic [1:0]           irq_flags;

   // Select high holds the frame logic in reset, so clock and data are ignored.
   assign frame_rst = rst | port_select_n; // see R19
   assign rx_byte   = {shreg, spi_mosi};
   assign byte_end  = (bit_cnt == 3'h7);

   function automatic logic [7:0] rd_mux(input logic [5:0] a, input logic [7:0] s, input logic [7:0] m,
                                         input logic [7:0] d, input logic [3:0] st);
      logic [7:0] v;
      v = 8'h00;
      unique case (a)
         `PMS_ADDR_STATE:  v = s;
         `PMS_ADDR_MISC:   v = m;
         `PMS_ADDR_MOD3:   v = d;
         `PMS_ADDR_STATUS: begin
            v[`PMS_BIT_OSC]   = st[3]; // see R13
            v[`PMS_BIT_READY] = st[2];
         end
         `PMS_ADDR_IRQ:    v[1:0] = st[1:0];
         default:          v = 8'h00; // see R26
      endcase
      return v;
   endfunction

   // Bits are shifted in on the falling edge, most significant first.
   always_ff @(negedge spi_sclk or posedge frame_rst) begin // see R20
      if (frame_rst) begin
         bit_cnt    <= 3'h0;
         shreg      <= 7'h00;
         first_done <= 1'b0;
         op         <= pms_pkg::PMS_OP_WRITE;
         addr       <= 6'h00;
      end else begin
         bit_cnt <= bit_cnt + 3'h1;
         shreg   <= rx_byte[6:0];
         if (byte_end) begin
            if (!first_done) begin
               first_done <= 1'b1;
               op         <= pms_pkg::pms_op_t'(rx_byte[7:6]); // see R21
               addr       <= rx_byte[5:0];
            end else begin
               addr <= addr + 6'h01; // see R22
            end
         end
      end
   end

   // Register file; only whole data bytes of write frames reach it.
   always_ff @(negedge spi_sclk or posedge rst) begin
      if (rst) begin
         state_reg <= `PMS_RST_STATE;
         misc_reg  <= `PMS_RST_MISC;
         mod3_reg  <= `PMS_RST_MOD3;
      end else if (!port_select_n && first_done && byte_end && op == pms_pkg::PMS_OP_WRITE) begin // see R24 R28
         unique case (addr)
            `PMS_ADDR_STATE: state_reg <= rx_byte;
            `PMS_ADDR_MISC:  misc_reg  <= rx_byte;
            `PMS_ADDR_MOD3:  mod3_reg  <= rx_byte;
            default: ; // see R25
         endcase
      end
   end

   // Direct command handed to the system domain by a toggle with stable id.
   always_ff @(negedge spi_sclk or posedge rst) begin
      if (rst) begin
         cmd_id  <= 6'h00;
         cmd_tgl <= 1'b0;
      end else if (!port_select_n && !first_done && byte_end && rx_byte[7:6] == pms_pkg::PMS_OP_CMD) begin // see R27 R28
         cmd_id  <= rx_byte[5:0];
         cmd_tgl <= ~cmd_tgl;
      end
   end

   // Read data is loaded at each byte boundary of a read frame.
   assign rd_load = !port_select_n && byte_end &&
                    (first_done ? (op == pms_pkg::PMS_OP_READ) : (rx_byte[7:6] == pms_pkg::PMS_OP_READ));
   assign rd_addr = first_done ? (addr + 6'h01) : rx_byte[5:0];

   always_ff @(negedge spi_sclk or posedge rst) begin
      if (rst) begin
         tx_byte <= 8'h00;
         clr_tgl <= 1'b0;
      end else if (rd_load) begin
         tx_byte <= rd_mux(rd_addr, state_reg, misc_reg, mod3_reg, st_link);
         if (rd_addr == `PMS_ADDR_IRQ) begin
            clr_tgl <= ~clr_tgl;
         end
      end
   end

   // Status bits are brought over to the link clock for reading.
   always_ff @(negedge spi_sclk or posedge rst) begin
      if (rst) begin
         st_meta <= 4'h0;
         st_link <= 4'h0;
      end else begin
         st_meta <= {osc_s, field_ready, irq_flags};
         st_link <= st_meta;
      end
   end

   // Output bits change on the rising edge; the pin is driven only for read data.
   always_ff @(posedge spi_sclk or posedge frame_rst) begin
      if (frame_rst) begin
         spi_miso_o  <= 1'b0;
         spi_miso_oe <= 1'b0;
      end else begin
         spi_miso_o  <= tx_byte[3'h7 - bit_cnt];
         spi_miso_oe <= first_done && op == pms_pkg::PMS_OP_READ; // see R23
      end
   end

   assign miso_pd_en = !spi_miso_oe && (misc_reg[`PMS_BIT_PD_A] || misc_reg[`PMS_BIT_PD_B]); // see R23

   // ********************************************************************
   // System domain crossings
   // ********************************************************************

   logic [9:0]           sy_meta;
   logic [9:0]           sy_sync;
   logic [1:0]           tg_last;
   logic [2:0]           mod_last;
   logic                 en_s;
   logic                 gap_s;
   logic                 field_bit_s;
   logic                 stby_s;
   logic                 cmd_pulse;
   logic                 clr_pulse;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sy_meta <= 10'h000;
         sy_sync <= 10'h000;
         tg_last <= 2'h0;
         mod_last <= 3'h0;
      end else if (ce) begin
         sy_meta <= {en, osc_stable, supply_gap_ok, state_reg[`PMS_BIT_FIELD], state_reg[`PMS_BIT_STBY],
                     mod3_reg[`PMS_BIT_LIN], mod3_reg[`PMS_BIT_TRF +: 2], cmd_tgl, clr_tgl};
         sy_sync <= sy_meta;
         tg_last <= sy_sync[1:0];
         mod_last <= sy_sync[4:2];
      end
   end

   assign {en_s, osc_s, gap_s, field_bit_s, stby_s} = sy_sync[9:5];
   assign cmd_pulse = ce && (sy_sync[1] != tg_last[1]);
   assign clr_pulse = ce && (sy_sync[0] != tg_last[0]);

   // The ramp field is taken only once two samples agree, so bits that resolve apart never mix.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ramp_linear <= 1'b0;
         ramp_time   <= 2'h0;
      end else if (ce && sy_sync[4:2] == mod_last) begin
         ramp_linear <= sy_sync[4];
         ramp_time   <= sy_sync[3:2];
      end
   end

   // ********************************************************************
   // Power modes
   // ********************************************************************

   pms_pkg::pms_pwr_t    pwr_st;
   pms_pkg::pms_pwr_t    next_pwr;
   logic                 normal;

   always_comb begin
      if (!en_s) begin
         next_pwr = pms_pkg::PMS_PWR_DOWN; // see R07
      end else if (pwr_st == pms_pkg::PMS_PWR_DOWN) begin
         next_pwr = pms_pkg::PMS_PWR_NORMAL; // see R11
      end else if (stby_s) begin
         next_pwr = pms_pkg::PMS_PWR_STANDBY; // see R08
      end else begin
         next_pwr = pms_pkg::PMS_PWR_NORMAL; // see R09
      end
   end

   // Control outputs follow the mode; register contents are untouched by it.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pwr_st  <= pms_pkg::PMS_PWR_DOWN;
         pwr_ctl <= '0;
      end else if (ce) begin
         pwr_st <= next_pwr;
         pwr_ctl.regs_on   <= next_pwr != pms_pkg::PMS_PWR_DOWN;
         pwr_ctl.low_power <= next_pwr == pms_pkg::PMS_PWR_STANDBY; // see R08
         pwr_ctl.pll_on    <= next_pwr == pms_pkg::PMS_PWR_NORMAL; // see R11
         pwr_ctl.tx_on     <= next_pwr == pms_pkg::PMS_PWR_NORMAL;
         pwr_ctl.rx_on     <= next_pwr == pms_pkg::PMS_PWR_NORMAL;
      end
   end

   assign normal = (pwr_st == pms_pkg::PMS_PWR_NORMAL);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         host_clock_output <= 1'b0;
      end else if (ce) begin
         host_clock_output <= osc_s && pwr_st != pms_pkg::PMS_PWR_DOWN && !host_clock_output;
      end
   end

   // ********************************************************************
   // Field ramp
   // ********************************************************************

   pms_pkg::pms_rf_t     rf_st;
   logic [11:0]          ramp_cnt;
   logic [11:0]          ramp_len;
   logic                 armed;
   logic                 rf_req;
   logic                 ana_evt;
   logic                 seq_field;

   // Leaving power-down the field stays off until the enable bit is seen low.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         armed <= 1'b0;
      end else if (ce) begin
         armed <= normal ? (armed || !field_bit_s) : 1'b0; // see R11
      end
   end

   assign rf_req   = normal && ((field_bit_s && armed) || seq_field);
   assign ramp_len = 12'(`PMS_RAMP_CYC) << ramp_time; // see R15

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rf_st       <= pms_pkg::PMS_RF_OFF;
         ramp_cnt    <= 12'h000;
         field_ready <= 1'b0;
         ana_evt     <= 1'b0;
      end else if (ce) begin
         ana_evt <= 1'b0;
         if (pwr_st == pms_pkg::PMS_PWR_DOWN) begin
            rf_st       <= pms_pkg::PMS_RF_OFF; // see R07
            field_ready <= 1'b0;
         end else begin
            unique case (rf_st)
               pms_pkg::PMS_RF_OFF: if (rf_req) begin
                  rf_st    <= pms_pkg::PMS_RF_UP; // see R15
                  ramp_cnt <= ramp_len - 12'h001;
               end
               pms_pkg::PMS_RF_UP: if (ramp_cnt == 12'h000) begin
                  rf_st       <= pms_pkg::PMS_FIELD_ENABLE_BIT; // see R18
                  field_ready <= 1'b1; // see R16
                  ana_evt     <= 1'b1;
               end else begin
                  ramp_cnt <= ramp_cnt - 12'h001;
               end
               pms_pkg::PMS_FIELD_ENABLE_BIT: if (!rf_req) begin
                  rf_st    <= pms_pkg::PMS_RF_DOWN; // see R17
                  ramp_cnt <= ramp_len - 12'h001;
               end
               pms_pkg::PMS_RF_DOWN: if (ramp_cnt == 12'h000) begin
                  rf_st       <= pms_pkg::PMS_RF_OFF;
                  field_ready <= 1'b0; // see R17
                  ana_evt     <= 1'b1;
               end else begin
                  ramp_cnt <= ramp_cnt - 12'h001;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         field_on      <= 1'b0;
         field_ramping <= 1'b0;
      end else if (ce) begin
         field_on      <= rf_st != pms_pkg::PMS_RF_OFF;
         field_ramping <= rf_st == pms_pkg::PMS_RF_UP || rf_st == pms_pkg::PMS_RF_DOWN;
      end
   end

   // ********************************************************************
   // Automatic supply level sequencer
   // ********************************************************************

   pms_pkg::pms_seq_t    seq_st;
   logic [13:0]          step_cnt;
   logic [2:0]           level;
   logic                 auto_active;
   logic                 cmd_evt;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         seq_st      <= pms_pkg::PMS_SEQ_IDLE;
         step_cnt    <= 14'h0000;
         level       <= `PMS_LVL_TOP;
         auto_active <= 1'b0;
         seq_field   <= 1'b0;
         cmd_evt     <= 1'b0;
      end else if (ce) begin
         cmd_evt <= 1'b0;
         if (pwr_st == pms_pkg::PMS_PWR_DOWN) begin
            seq_st      <= pms_pkg::PMS_SEQ_IDLE; // see R29
            auto_active <= 1'b0;
            seq_field   <= 1'b0;
         end else begin
            unique case (seq_st)
               pms_pkg::PMS_SEQ_IDLE: if (cmd_pulse && cmd_id == `PMS_CMD_AUTO && normal) begin
                  seq_st      <= pms_pkg::PMS_SEQ_STEP; // see R01
                  auto_active <= 1'b1;
                  level       <= `PMS_LVL_TOP; // see R04
                  seq_field   <= 1'b1;
                  step_cnt    <= 14'(STEP_CYC - 1);
               end else if (cmd_pulse && cmd_id == `PMS_CMD_MAN) begin
                  auto_active <= 1'b0; // see R02
                  cmd_evt     <= 1'b1;
               end
               pms_pkg::PMS_SEQ_STEP: if (step_cnt != 14'h0000) begin
                  step_cnt <= step_cnt - 14'h0001;
               end else if (gap_s || level == `PMS_LVL_FLOOR) begin
                  seq_st    <= pms_pkg::PMS_SEQ_IDLE; // see R06
                  seq_field <= 1'b0;
                  cmd_evt   <= 1'b1;
               end else begin
                  level    <= level - 3'h1; // see R05
                  step_cnt <= 14'(STEP_CYC - 1);
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         regulator_level <= `PMS_LVL_TOP;
      end else if (ce) begin
         regulator_level <= auto_active ? level : reg_sel_level; // see R02
      end
   end

   // Sticky flags; a new event wins over a clear in the same cycle.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         irq_flags <= 2'h0;
         irq       <= 1'b0;
      end else if (ce) begin
         irq_flags[`PMS_BIT_IRQ_ANA] <= ana_evt || (irq_flags[`PMS_BIT_IRQ_ANA] && !clr_pulse); // see R16
         irq_flags[`PMS_BIT_IRQ_CMD] <= cmd_evt || (irq_flags[`PMS_BIT_IRQ_CMD] && !clr_pulse); // see R06
         irq <= ana_evt || cmd_evt || (|irq_flags && !clr_pulse);
      end
   end

   // ********************************************************************
   // Assertions
   // ********************************************************************

   a_pdown_field: assert property (@(posedge clk_sys) disable iff (rst) // see R07
      pwr_st == pms_pkg::PMS_PWR_DOWN && ce |-> !pwr_ctl.regs_on ##1 rf_st == pms_pkg::PMS_RF_OFF)
      else $error("Field or regulators active in power-down.");
   a_stby_blocks: assert property (@(posedge clk_sys) disable iff (rst) // see R08
      pwr_st == pms_pkg::PMS_PWR_STANDBY |-> pwr_ctl.low_power && !pwr_ctl.pll_on && !pwr_ctl.tx_on)
      else $error("Standby controls wrong.");
   a_enable_normal: assert property (@(posedge clk_sys) disable iff (rst) // see R11
      $past(pwr_st) == pms_pkg::PMS_PWR_DOWN && pwr_st == pms_pkg::PMS_PWR_NORMAL |-> !field_bit_s || !armed)
      else $error("Field armed on leaving power-down.");
   a_auto_start: assert property (@(posedge clk_sys) disable iff (rst) // see R04
      seq_st == pms_pkg::PMS_SEQ_IDLE && cmd_pulse && cmd_id == `PMS_CMD_AUTO && normal
      |=> level == `PMS_LVL_TOP && seq_field && auto_active)
      else $error("Auto level start wrong.");
   a_step_down: assert property (@(posedge clk_sys) disable iff (rst) // see R05
      seq_st == pms_pkg::PMS_SEQ_STEP && $past(seq_st) == pms_pkg::PMS_SEQ_STEP && level != $past(level)
      |-> level == $past(level) - 3'h1 && $past(step_cnt) == 14'h0000)
      else $error("Level step wrong.");
   a_auto_end: assert property (@(posedge clk_sys) disable iff (rst) // see R06
      $past(normal) && $fell(seq_st == pms_pkg::PMS_SEQ_STEP) |-> !seq_field ##1 irq_flags[`PMS_BIT_IRQ_CMD] && irq)
      else $error("Auto level end wrong.");
   a_ramp_time: assert property (@(posedge clk_sys) disable iff (rst) // see R18
      $rose(rf_st == pms_pkg::PMS_RF_UP) && ramp_time == 2'h0 && ce |-> ##[500:500] rf_st == pms_pkg::PMS_FIELD_ENABLE_BIT)
      else $error("Ramp-up time wrong.");
   a_ready_up: assert property (@(posedge clk_sys) disable iff (rst) // see R16
      $rose(rf_st == pms_pkg::PMS_FIELD_ENABLE_BIT) |-> field_ready ##1 irq_flags[`PMS_BIT_IRQ_ANA])
      else $error("Ready or analog flag missing.");
   a_ready_down: assert property (@(posedge clk_sys) disable iff (rst) // see R17
      $past(rf_st) == pms_pkg::PMS_RF_DOWN && rf_st == pms_pkg::PMS_RF_OFF && ce |-> !field_ready)
      else $error("Ready not cleared.");
   a_pd_abort: assert property (@(posedge clk_sys) disable iff (rst) // see R29
      pwr_st == pms_pkg::PMS_PWR_DOWN && ce |=> !auto_active && seq_st == pms_pkg::PMS_SEQ_IDLE)
      else $error("Sequencer not aborted.");
   a_miso_release: assert property (@(posedge spi_sclk) disable iff (frame_rst) // see R23
      op != pms_pkg::PMS_OP_READ |=> !spi_miso_oe)
      else $error("Output driven outside read.");
   c_ramp_up: cover property (@(posedge clk_sys) disable iff (rst) $rose(field_ready));
   c_auto_done: cover property (@(posedge clk_sys) disable iff (rst) $fell(seq_st == pms_pkg::PMS_SEQ_STEP));
   c_standby: cover property (@(posedge clk_sys) disable iff (rst) pwr_st == pms_pkg::PMS_PWR_STANDBY);
   c_read: cover property (@(posedge spi_sclk) disable iff (frame_rst) spi_miso_oe);

endmodule

/* pms_top_tb.sv */
// Self-checking bench for pms_top; host frames come from pms_host.
// Assumes STEP_CYC of 20 and ramp length 500 << ramp_time cycles.
module pms_top_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_sys, rst, ce, en, osc_stable, supply_gap_ok;
   logic [2:0] reg_sel_level;
   logic spi_sclk, port_select_n, spi_mosi, spi_miso_o, spi_miso_oe, miso_pd_en;
   logic irq, host_clock_output, field_on, field_ramping, ramp_linear;
   logic [2:0] regulator_level;
   logic [1:0] ramp_time;
   pms_pkg::pms_pwr_ctl_t pwr_ctl;
   logic [23:0] rx;
   logic hc;
   int error_cnt = 0;
   int num_checks = 0;
   pms_top #(.STEP_CYC(20)) pms_top_inst (.clk_sys(clk_sys), .rst(rst), .ce(ce), .en(en),
      .osc_stable(osc_stable), .supply_gap_ok(supply_gap_ok), .reg_sel_level(reg_sel_level),
      .spi_sclk(spi_sclk), .port_select_n(port_select_n), .spi_mosi(spi_mosi),
      .spi_miso_o(spi_miso_o), .spi_miso_oe(spi_miso_oe), .miso_pd_en(miso_pd_en), .irq(irq),
      .host_clock_output(host_clock_output), .regulator_level(regulator_level),
      .field_on(field_on), .field_ramping(field_ramping), .ramp_linear(ramp_linear),
      .ramp_time(ramp_time), .pwr_ctl(pwr_ctl));
   pms_host pms_host_inst (.spi_sclk(spi_sclk), .port_select_n(port_select_n), .spi_mosi(spi_mosi),
      .spi_miso_o(spi_miso_o), .spi_miso_oe(spi_miso_oe), .miso_pd_en(miso_pd_en));
   // ****************************************
   // Tasks
   // ****************************************
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      pms_host_inst.frame({2'b00, a, d, 8'h00}, 16, rx);
   endtask
   task automatic rd(input logic [5:0] a, input logic [7:0] exp);
      pms_host_inst.frame({2'b01, a, 16'h0000}, 16, rx);
      chk(rx[15:8], exp);
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ****************************************
   // Clock, watchdog and tests
   // ****************************************
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = !clk_sys;
   end
   initial begin
      #1ms error_cnt++;
      stop_test();
   end
   initial begin
      rst = 1'b1; ce = 1'b1; en = 1'b0; osc_stable = 1'b1; supply_gap_ok = 1'b0; reg_sel_level = 3'h5;
      cyc(20);
      rst = 1'b0;
      en = 1'b1;
      cyc(10);
      chk(pwr_ctl.regs_on, 8'h01);
      hc = host_clock_output;
      cyc(1);
      chk(host_clock_output, {7'h00, !hc});
      chk(field_on, 8'h00);
      rd(6'h00, 8'h00);
      rd(6'h0D, 8'h00);
      rd(6'h15, 8'h00);
      rd(6'h2A, 8'h80);
      pms_host_inst.frame({2'b00, 6'h14, 8'hAA, 8'h05}, 24, rx);
      pms_host_inst.frame({2'b01, 6'h14, 16'h0000}, 24, rx);
      chk(rx[15:8], 8'h00);
      chk(rx[7:0], 8'h05);
      chk(ramp_time, 8'h01);
      chk(ramp_linear, 8'h01);
      pms_host_inst.frame({2'b00, 6'h0D, 16'hF000}, 12, rx);
      rd(6'h0D, 8'h00);
      pms_host_inst.frame({2'b11, 6'h00, 16'h8000}, 16, rx);
      rd(6'h00, 8'h00);
      wr(6'h0D, 8'h03);
      chk(miso_pd_en, 8'h01);
      wr(6'h15, 8'h04);
      wr(6'h00, 8'h80);
      cyc(5);
      chk(field_ramping, 8'h01);
      cyc(480);
      chk(field_ramping, 8'h01);
      cyc(30);
      chk({field_on, field_ramping, irq}, 8'h05);
      rd(6'h2A, 8'hC0);
      rd(6'h38, 8'h01);
      cyc(10);
      chk(irq, 8'h00);
      wr(6'h00, 8'h00);
      cyc(520);
      rd(6'h2A, 8'h80);
      rd(6'h38, 8'h01);
      pms_host_inst.frame({8'hA2, 16'h0000}, 8, rx);
      cyc(8);
      chk({regulator_level, field_on}, 8'h0F);
      cyc(20);
      chk(regulator_level, 8'h06);
      supply_gap_ok = 1'b1;
      cyc(40);
      chk({regulator_level, irq}, 8'h0D);
      pms_host_inst.frame({2'b01, 6'h38, 16'h0000}, 16, rx);
      chk(rx[9], 8'h01);
      pms_host_inst.frame({8'hA3, 16'h0000}, 8, rx);
      cyc(10);
      chk(regulator_level, 8'h05);
      wr(6'h00, 8'h40);
      cyc(10);
      chk({pwr_ctl.low_power, pwr_ctl.pll_on, pwr_ctl.tx_on, pwr_ctl.rx_on}, 8'h08);
      rd(6'h0D, 8'h03);
      wr(6'h00, 8'h00);
      cyc(10);
      chk({pwr_ctl.low_power, pwr_ctl.pll_on}, 8'h01);
      en = 1'b0;
      cyc(10);
      chk(pwr_ctl.regs_on, 8'h00);
      chk(host_clock_output, 8'h00);
      stop_test();
   end
endmodule
